//--- rtl/csi_core_ctrl.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Register file offers 8/8, 8+8/8, 8+8/16 and 16/16 read/write port schemes.
// - The 32 working registers also answer at data addresses 0 to 31.
// - Registers 26..31 form three 16-bit pointers with displacement, increment, decrement.
// - Stack grows down: push -1, call/entry -2, pop +1, return +2.
// - Stack pointer bytes at I/O 0x3E and 0x3D, read/write, reset to top of RAM.
// - Core runs on the undivided clock, fetching next instruction while executing.
// - Two-operand ALU operation reads, computes and writes back in one cycle.
// - Reset and each source own a low vector; lower vector is higher priority.
// - Interrupt taken only with its own enable and the global enable both set.
// - Relocate bit moves interrupt vectors to boot start; fuse moves reset vector.
// - Entry clears global enable; software may set it; handler return sets it.
// - Flag-type pending flag cleared on vectoring; writing one also clears it.
// - Flags raised while disabled stay pending, then serviced in priority order.
// - Level-type requests exist only while the condition holds.
// - After handler return one more program instruction runs before any interrupt.
// - Flag register is neither saved on entry nor restored on return.
// - Global mask acts at once; no interrupt follows it, even in the same cycle.
// - After global unmask the next instruction runs before any interrupt.
// - Entry takes four cycles pushing the program counter, then the vector runs.
// - Multi-cycle instructions finish first; wake from sleep adds four cycles.
// - Return takes four cycles: pop two bytes, stack pointer +2, set global enable.
module csi_core_ctrl #(
  parameter int NIRQ = 8,
  parameter logic [NIRQ-1:0] FLAG_TYPE = '1,
  parameter logic [15:0] RAM_TOP = csi_pkg::TOP_OF_RAM
)(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [4:0] rf_rd_a,
  input wire logic [4:0] rf_rd_b,
  output logic [7:0] rf_opa_q,
  output logic [7:0] rf_opb_q,
  output logic [15:0] rf_opw_q,
  input wire logic [4:0] rf_wr_addr,
  input wire logic [15:0] rf_wr_data,
  input wire logic rf_wr_en8,
  input wire logic rf_wr_en16,
  input wire logic [15:0] ds_addr,
  input wire logic ds_we,
  input wire logic [7:0] ds_wdata,
  output logic [7:0] ds_rdata_q,
  input wire logic [1:0] ptr_sel,
  input wire logic [5:0] ptr_disp,
  input wire logic ptr_inc,
  input wire logic ptr_dec,
  output logic [15:0] ptr_addr_q,
  input wire logic [5:0] io_addr,
  input wire logic io_we,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata_q,
  input wire logic instr_done,
  input wire logic op_push,
  input wire logic op_pop,
  input wire logic op_call,
  input wire logic op_ret,
  input wire logic op_handler_return_op,
  input wire logic op_cli,
  input wire logic op_sei,
  input wire logic sleeping,
  input wire logic alu_flags_we,
  input wire logic [6:0] alu_flags,
  input wire logic [NIRQ-1:0] irq_enable,
  input wire logic [NIRQ-1:0] irq_event,
  input wire logic [NIRQ-1:0] irq_level,
  input wire logic [NIRQ-1:0] flag_w1c,
  output logic [NIRQ-1:0] irq_flag_q,
  input wire logic reset_vector_relocate_fuse,
  input wire logic [15:0] pc_in,
  output logic [15:0] reset_vector_q,
  output logic irq_ack_q,
  output logic pc_load_q,
  output logic [15:0] pc_value_q,
  output logic core_stall_q,
  output logic stk_we_q,
  output logic stk_re_q,
  output logic [15:0] stk_addr_q,
  output logic [7:0] stk_wdata_q,
  input wire logic [7:0] stk_rdata,
  output logic [7:0] flag_register_q,
  output logic [15:0] sp_q
);

  localparam int IW = $clog2(NIRQ);
  // Vector spacing in program words
  localparam logic [15:0] VEC_MUL = csi_pkg::VEC_STRIDE;

  logic [1:0] rst_sync_q;
  logic rst_n;
  csi_pkg::csi_state_t state_q;
  logic [1:0] cnt_q;
  logic [IW-1:0] irq_idx_q;
  logic [15:0] pc_hold_q;
  logic [7:0] ctl_q;
  logic block_q;
  logic [NIRQ-1:0] req;
  logic [IW-1:0] pick_idx;
  logic any_req;
  logic take;
  logic cli_now;
  logic sei_now;
  logic ret_end;
  logic entry_push;
  logic ret_pop;
  logic [15:0] vec_base;
  logic ds_hit;
  logic [7:0] rf_opa;
  logic [7:0] rf_opb;
  logic [15:0] rf_opw;
  logic [7:0] rf_ds_rdata;
  logic [15:0] ptr_x;
  logic [15:0] ptr_y;
  logic [15:0] ptr_z;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  // Two-stage release keeps the deassertion edge clean for all flops reset by rst_n
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // Register file and its data-space window
  // ----------------------------------------------------------------
  assign ds_hit = ds_addr < 16'(csi_pkg::NUM_REGS);

  csi_regfile #(
    .NREG(csi_pkg::NUM_REGS)
  ) u_regfile (
    .clk(clk),
    .rst_n(rst_n),
    .rd_a(rf_rd_a),
    .rd_b(rf_rd_b),
    .opa(rf_opa),
    .opb(rf_opb),
    .opw(rf_opw),
    .wr_addr(rf_wr_addr),
    .wr_data(rf_wr_data),
    .wr_en8(rf_wr_en8),
    .wr_en16(rf_wr_en16),
    .ds_addr(ds_addr[4:0]),
    .ds_we(ds_we && ds_hit),
    .ds_wdata(ds_wdata),
    .ds_rdata(rf_ds_rdata),
    .ptr_sel(ptr_sel),
    .ptr_inc(ptr_inc),
    .ptr_dec(ptr_dec),
    .ptr_x(ptr_x),
    .ptr_y(ptr_y),
    .ptr_z(ptr_z)
  );

  // Operands registered at the port; a pointer address carries its displacement
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rf_opa_q <= 8'h00;
      rf_opb_q <= 8'h00;
      rf_opw_q <= 16'h0000;
      ds_rdata_q <= 8'h00;
      ptr_addr_q <= 16'h0000;
    end else begin
      rf_opa_q <= rf_opa;
      rf_opb_q <= rf_opb;
      rf_opw_q <= rf_opw;
      ds_rdata_q <= ds_hit ? rf_ds_rdata : 8'h00;
      case (ptr_sel)
        2'h0: ptr_addr_q <= ptr_x + {10'h000, ptr_disp};
        2'h1: ptr_addr_q <= ptr_y + {10'h000, ptr_disp};
        default: ptr_addr_q <= ptr_z + {10'h000, ptr_disp};
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Request sources and priority
  // ----------------------------------------------------------------
  // Level sources are not latched, so a vanished condition never fires
  assign req = ((irq_flag_q & FLAG_TYPE) | (irq_level & ~FLAG_TYPE)) & irq_enable;

  // Lowest index is the lowest vector and so the highest priority
  always_comb begin
    pick_idx = '0;
    any_req = 1'b0;
    for (int i = NIRQ - 1; i >= 0; i--) begin
      if (req[i]) begin
        pick_idx = IW'(i);
        any_req = 1'b1;
      end
    end
  end

  assign cli_now = instr_done && op_cli;
  assign sei_now = instr_done && op_sei;
  assign ret_end = state_q == csi_pkg::ST_RETURN && cnt_q == csi_pkg::RETURN_LAST;
  assign entry_push = state_q == csi_pkg::ST_ENTRY && !cnt_q[1];
  assign ret_pop = state_q == csi_pkg::ST_RETURN && !cnt_q[1];

  // Only at an instruction boundary, so a multi-cycle instruction finishes
  assign take = state_q == csi_pkg::ST_RUN && (instr_done || sleeping)
      && flag_register_q[csi_pkg::FLAG_GIE_BIT] && !cli_now
      && !block_q && any_req;

  // Flags: a new event beats a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_flag_q <= '0;
    end else begin
      for (int i = 0; i < NIRQ; i++) begin
        irq_flag_q[i] <= FLAG_TYPE[i] && (irq_event[i] || (irq_flag_q[i]
            && !flag_w1c[i] && !(take && pick_idx == IW'(i))));
      end
    end
  end

  // ----------------------------------------------------------------
  // Entry, wake and return sequencer
  // ----------------------------------------------------------------
  assign vec_base = ctl_q[csi_pkg::CTL_RELOC_BIT] ? csi_pkg::BOOT_START : csi_pkg::APP_START;

  // The core stalls during each phase; otherwise fetch overlaps execute
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= csi_pkg::ST_RUN;
      cnt_q <= 2'h0;
      irq_idx_q <= '0;
      pc_hold_q <= 16'h0000;
      irq_ack_q <= 1'b0;
      pc_load_q <= 1'b0;
      pc_value_q <= 16'h0000;
      core_stall_q <= 1'b0;
      stk_we_q <= 1'b0;
      stk_re_q <= 1'b0;
      stk_addr_q <= 16'h0000;
      stk_wdata_q <= 8'h00;
    end else begin
      irq_ack_q <= 1'b0;
      pc_load_q <= 1'b0;
      stk_we_q <= 1'b0;
      stk_re_q <= 1'b0;
      cnt_q <= cnt_q + 2'h1;
      case (state_q)
        csi_pkg::ST_RUN: begin
          cnt_q <= 2'h0;
          if (take) begin
            irq_ack_q <= 1'b1;
            irq_idx_q <= pick_idx;
            pc_hold_q <= pc_in;
            core_stall_q <= 1'b1;
            state_q <= sleeping ? csi_pkg::ST_WAKE : csi_pkg::ST_ENTRY;
          end else if (instr_done && op_handler_return_op) begin
            core_stall_q <= 1'b1;
            state_q <= csi_pkg::ST_RETURN;
          end else begin
            core_stall_q <= 1'b0;
          end
        end
        csi_pkg::ST_WAKE: begin
          if (cnt_q == csi_pkg::WAKE_LAST) begin
            state_q <= csi_pkg::ST_ENTRY;
          end
        end
        csi_pkg::ST_ENTRY: begin
          // Flag register is left untouched here; software saves it
          if (entry_push) begin
            stk_we_q <= 1'b1;
            stk_addr_q <= sp_q;
            stk_wdata_q <= cnt_q[0] ? pc_hold_q[15:8] : pc_hold_q[7:0];
          end
          if (cnt_q == csi_pkg::ENTRY_LAST) begin
            pc_load_q <= 1'b1;
            pc_value_q <= vec_base + 16'(VEC_MUL * ({{(16-IW){1'b0}}, irq_idx_q} + 16'h0001));
            core_stall_q <= 1'b0;
            state_q <= csi_pkg::ST_RUN;
          end
        end
        csi_pkg::ST_RETURN: begin
          // Stack read data arrives one cycle after the strobe
          if (ret_pop) begin
            stk_re_q <= 1'b1;
            stk_addr_q <= sp_q + 16'h0001;
          end
          if (cnt_q == 2'h2) begin
            pc_hold_q[15:8] <= stk_rdata;
          end
          if (ret_end) begin
            pc_load_q <= 1'b1;
            pc_value_q <= {pc_hold_q[15:8], stk_rdata};
            core_stall_q <= 1'b0;
            state_q <= csi_pkg::ST_RUN;
          end
        end
        default: begin
          state_q <= csi_pkg::ST_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Stack pointer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_q <= RAM_TOP;
    end else if (io_we && io_addr == csi_pkg::IO_SPL) begin
      sp_q[7:0] <= io_wdata;
    end else if (io_we && io_addr == csi_pkg::IO_SPH) begin
      sp_q[15:8] <= io_wdata;
    end else if (entry_push) begin
      sp_q <= sp_q - 16'h0001;
    end else if (ret_pop) begin
      sp_q <= sp_q + 16'h0001;
    end else if (state_q == csi_pkg::ST_RUN && instr_done && !take) begin
      if (op_push) begin
        sp_q <= sp_q - 16'h0001;
      end else if (op_pop) begin
        sp_q <= sp_q + 16'h0001;
      end else if (op_call) begin
        sp_q <= sp_q - 16'h0002;
      end else if (op_ret) begin
        sp_q <= sp_q + 16'h0002;
      end
    end
  end

  // ----------------------------------------------------------------
  // Flag register, control register, one-instruction hold
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_register_q <= csi_pkg::FLAGS_RST;
    end else begin
      if (take) begin
        flag_register_q[csi_pkg::FLAG_GIE_BIT] <= 1'b0;
      end else if (ret_end) begin
        flag_register_q[csi_pkg::FLAG_GIE_BIT] <= 1'b1;
      end else if (cli_now) begin
        flag_register_q[csi_pkg::FLAG_GIE_BIT] <= 1'b0;
      end else if (sei_now) begin
        flag_register_q[csi_pkg::FLAG_GIE_BIT] <= 1'b1;
      end else if (io_we && io_addr == csi_pkg::IO_FLAGS) begin
        flag_register_q[csi_pkg::FLAG_GIE_BIT] <= io_wdata[7];
      end
      if (io_we && io_addr == csi_pkg::IO_FLAGS) begin
        flag_register_q[6:0] <= io_wdata[6:0];
      end else if (alu_flags_we) begin
        flag_register_q[6:0] <= alu_flags;
      end
    end
  end

  // Hold blocks the boundary that ends the next instruction after unmask or return
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      block_q <= 1'b0;
    end else if (ret_end || sei_now) begin
      block_q <= 1'b1;
    end else if (instr_done) begin
      block_q <= 1'b0;
    end
  end

  // Fuse is sampled after reset release, never loaded by the async reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= csi_pkg::CTL_RST;
      reset_vector_q <= csi_pkg::APP_START;
    end else begin
      reset_vector_q <= reset_vector_relocate_fuse ? csi_pkg::BOOT_START : csi_pkg::APP_START;
      if (io_we && io_addr == csi_pkg::IO_CORECTL) begin
        ctl_q <= io_wdata;
      end
    end
  end

  // I/O read data, one cycle after the address; unmapped reads zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata_q <= 8'h00;
    end else begin
      case (io_addr)
        csi_pkg::IO_SPL: io_rdata_q <= sp_q[7:0];
        csi_pkg::IO_SPH: io_rdata_q <= sp_q[15:8];
        csi_pkg::IO_FLAGS: io_rdata_q <= flag_register_q;
        csi_pkg::IO_CORECTL: io_rdata_q <= ctl_q;
        default: io_rdata_q <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_ENTRY_LEN: assert property (irq_ack_q |-> ##[4:8] pc_load_q)
    else $error("vector not loaded after entry");
  AST_ENTRY_AWAKE: assert property (irq_ack_q && state_q == csi_pkg::ST_ENTRY |-> !pc_load_q [*4] ##1 pc_load_q)
    else $error("entry not four cycles");
  AST_GIE_CLEAR: assert property (irq_ack_q |-> !flag_register_q[csi_pkg::FLAG_GIE_BIT])
    else $error("global enable not cleared on entry");
  AST_TAKE_GIE: assert property (irq_ack_q |-> $past(flag_register_q[csi_pkg::FLAG_GIE_BIT]))
    else $error("taken while globally masked");
  AST_CLI_NOW: assert property (cli_now |=> !irq_ack_q)
    else $error("interrupt taken with mask instruction");
  AST_HOLD_ONE: assert property (block_q && instr_done |=> !irq_ack_q)
    else $error("interrupt taken before one instruction ran");
  AST_RET_DONE: assert property ($rose(state_q == csi_pkg::ST_RETURN) |-> ##4 pc_load_q
      && flag_register_q[csi_pkg::FLAG_GIE_BIT] && sp_q == $past(sp_q, 4) + 16'h0002)
    else $error("return sequence wrong");
  AST_PUSH_DEC: assert property (state_q == csi_pkg::ST_RUN && instr_done && op_push && !take && !io_we
      |=> sp_q == $past(sp_q) - 16'h0001)
    else $error("push did not lower stack pointer");

endmodule // csi_core_ctrl

//--- rtl/csi_pkg.sv
package csi_pkg;

  // ----------------------------------------------------------------
  // I/O register map (six-bit I/O addresses)
  // ----------------------------------------------------------------
  localparam logic [5:0] IO_SPL = 6'h3D;
  localparam logic [5:0] IO_SPH = 6'h3E;
  localparam logic [5:0] IO_FLAGS = 6'h3F;
  localparam logic [5:0] IO_CORECTL = 6'h35;

  // Field positions
  localparam int CTL_RELOC_BIT = 1;
  localparam int FLAG_GIE_BIT = 7;

  // Values after reset
  localparam logic [15:0] TOP_OF_RAM = 16'h04FF;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] CTL_RST = 8'h00;

  // Program memory layout, in words
  localparam logic [15:0] APP_START = 16'h0000;
  localparam logic [15:0] BOOT_START = 16'h1C00;
  localparam logic [15:0] VEC_STRIDE = 16'h0002;

  // Register file layout
  localparam int NUM_REGS = 32;
  localparam logic [4:0] PTR_BASE = 5'h1A;

  // Cycle counts, last index of each four-cycle phase
  localparam logic [1:0] ENTRY_LAST = 2'h3;
  localparam logic [1:0] RETURN_LAST = 2'h3;
  localparam logic [1:0] WAKE_LAST = 2'h3;

  // Sequencer states
  typedef enum logic [1:0] {ST_RUN, ST_WAKE, ST_ENTRY, ST_RETURN} csi_state_t;

endpackage

//--- rtl/csi_regfile.sv
`timescale 1ns/10ps
module csi_regfile #(
  parameter int NREG = 32
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] rd_a,
  input wire logic [4:0] rd_b,
  output logic [7:0] opa,
  output logic [7:0] opb,
  output logic [15:0] opw,
  input wire logic [4:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_en8,
  input wire logic wr_en16,
  input wire logic [4:0] ds_addr,
  input wire logic ds_we,
  input wire logic [7:0] ds_wdata,
  output logic [7:0] ds_rdata,
  input wire logic [1:0] ptr_sel,
  input wire logic ptr_inc,
  input wire logic ptr_dec,
  output logic [15:0] ptr_x,
  output logic [15:0] ptr_y,
  output logic [15:0] ptr_z
);

  logic [7:0] regs_q [NREG];
  logic [4:0] plo;
  logic [15:0] pcur;
  logic [15:0] pnext;
  logic pupd;

  // ----------------------------------------------------------------
  // Read ports: 8-bit pair and 16-bit even/odd pair
  // ----------------------------------------------------------------
  assign opa = regs_q[rd_a];
  assign opb = regs_q[rd_b];
  assign opw = {regs_q[{rd_a[4:1], 1'b1}], regs_q[{rd_a[4:1], 1'b0}]};
  assign ds_rdata = regs_q[ds_addr];

  // Pointer pairs sit in the top six registers, low byte first
  assign ptr_x = {regs_q[csi_pkg::PTR_BASE + 1], regs_q[csi_pkg::PTR_BASE]};
  assign ptr_y = {regs_q[csi_pkg::PTR_BASE + 3], regs_q[csi_pkg::PTR_BASE + 2]};
  assign ptr_z = {regs_q[csi_pkg::PTR_BASE + 5], regs_q[csi_pkg::PTR_BASE + 4]};
  // Selects 2 and 3 both name the top pair; a plain sum would wrap to register 0
  assign plo = csi_pkg::PTR_BASE + {2'b00, (ptr_sel[1] ? 2'h2 : ptr_sel), 1'b0};
  assign pcur = {regs_q[{plo[4:1], 1'b1}], regs_q[plo]};
  assign pnext = ptr_inc ? pcur + 16'h0001 : pcur - 16'h0001;
  assign pupd = ptr_inc ^ ptr_dec;

  // ----------------------------------------------------------------
  // Write ports, one process per register; pointer update wins
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NREG; i++) begin : g_reg
    localparam logic [4:0] IDX = 5'(i);
    // Result is written in the same cycle the operands are read
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        regs_q[i] <= 8'h00;
      end else if (pupd && plo == IDX) begin
        regs_q[i] <= pnext[7:0];
      end else if (pupd && {plo[4:1], 1'b1} == IDX) begin
        regs_q[i] <= pnext[15:8];
      end else if (wr_en16 && {wr_addr[4:1], 1'b0} == IDX) begin
        regs_q[i] <= wr_data[7:0];
      end else if (wr_en16 && {wr_addr[4:1], 1'b1} == IDX) begin
        regs_q[i] <= wr_data[15:8];
      end else if (wr_en8 && wr_addr == IDX) begin
        regs_q[i] <= wr_data[7:0];
      end else if (ds_we && ds_addr == IDX) begin
        regs_q[i] <= ds_wdata;
      end
    end
  end

endmodule // csi_regfile

//--- bench/csi_stack_ram.sv
`timescale 1ns/10ps
// ----------------------------------------
// Stack memory on the far side of the core
// ----------------------------------------
module csi_stack_ram (
  input wire logic clk,
  input wire logic stk_we_q,
  input wire logic stk_re_q,
  input wire logic [15:0] stk_addr_q,
  input wire logic [7:0] stk_wdata_q,
  output logic [7:0] stk_rdata
);
  logic [7:0] mem_q [2048];

  // Read data is valid only in the cycle after the strobe; otherwise it is inverted every cycle, so a byte one cycle stale never passes
  always_ff @(posedge clk) begin
    if (stk_we_q) begin
      mem_q[stk_addr_q[10:0]] <= stk_wdata_q;
    end
    stk_rdata <= stk_re_q ? mem_q[stk_addr_q[10:0]] : ~stk_rdata;
  end
endmodule // csi_stack_ram

//--- bench/csi_core_ctrl_bench.sv
`timescale 1ns/10ps
module csi_core_ctrl_bench;
  // ----------------------------------------
  // Signals and bench state
  // ----------------------------------------
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] rf_rd_a, rf_rd_b, rf_wr_addr;
  logic [7:0] rf_opa_q, rf_opb_q, ds_wdata, ds_rdata_q, io_wdata, io_rdata_q, stk_wdata_q, stk_rdata;
  logic [7:0] flag_register_q, irq_enable, irq_event, irq_level, flag_w1c, irq_flag_q, regs [32];
  logic [15:0] rf_opw_q, rf_wr_data, ds_addr, ptr_addr_q, pc_in, reset_vector_q, pc_value_q, stk_addr_q, sp_q;
  logic rf_wr_en8, rf_wr_en16, ds_we, ptr_inc, ptr_dec, io_we, instr_done, op_push, op_pop, op_call, op_ret;
  logic op_handler_return_op, op_cli, op_sei, sleeping, alu_flags_we, reset_vector_relocate_fuse, irq_ack_q, pc_load_q;
  logic core_stall_q, stk_we_q, stk_re_q;
  logic [1:0] ptr_sel;
  logic [5:0] ptr_disp, io_addr;
  logic [6:0] alu_flags;
  logic [6:0] st_ops [4] = '{7'h40, 7'h20, 7'h10, 7'h08};
  logic [15:0] st_dsp [4] = '{16'hFFFF, 16'h0001, 16'hFFFE, 16'h0002};
  logic [15:0] sp_m = 16'h0234;
  logic [15:0] sv_pc;
  int seed = 63;
  int num_errors = 0;
  int checks_done = 0;

  // Source 7 is level-type so the unlatched request path is exercised
  csi_core_ctrl #(.FLAG_TYPE(8'h7F)) u_csi_core_ctrl (.*);
  csi_stack_ram u_csi_stack_ram (.*);

  // Core clock, 5 ns period
  always #2.5 clk = ~clk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic step(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk16(logic [15:0] got, logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(logic got, logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask
  // Each call holds its values for one whole cycle, so no signal changes twice in a time step
  task automatic cyc(logic done, logic [6:0] ops);
    instr_done = done;
    {op_push, op_pop, op_call, op_ret, op_handler_return_op, op_cli, op_sei} = ops;
    step();
  endtask
  task automatic io(logic [5:0] a, logic [7:0] d, logic we);
    io_addr = a;
    io_wdata = d;
    io_we = we;
    step();
  endtask
  task automatic wait_load(int exp);
    int n = 0;
    while (pc_load_q !== 1'b1 && n < 20) begin
      cyc(1'b0, 7'h00);
      n++;
    end
    chk16(16'(n), 16'(exp));
  endtask
  function automatic logic [15:0] pair(logic [4:0] a);
    return {regs[a | 5'h01], regs[a & 5'h1E]};
  endfunction
  function automatic logic [4:0] pbase(logic [1:0] s);
    return csi_pkg::PTR_BASE + {2'b00, (s[1] ? 2'h2 : s), 1'b0};
  endfunction
  task automatic unmask();
    cyc(1'b1, 7'h01);
    chk1(flag_register_q[7], 1'b1);
    cyc(1'b1, 7'h00);
    chk1(irq_ack_q, 1'b0);
  endtask
  task automatic take(int idx, logic [15:0] base, int lat, logic slp);
    sv_pc = 16'($random(seed));
    pc_in = sv_pc;
    sleeping = slp;
    cyc(!slp, 7'h00);
    sleeping = 1'b0;
    chk1(irq_ack_q, 1'b1);
    chk1(core_stall_q, 1'b1);
    chk1(flag_register_q[7], 1'b0);
    chk1(irq_flag_q[idx], 1'b0);
    wait_load(lat);
    chk16(pc_value_q, base + 16'(2 * (idx + 1)));
    chk16(sp_q, sp_m - 16'h0002);
  endtask
  // Handler rewrites the flags; the return must keep them and only set the global enable
  task automatic back();
    alu_flags = 7'h55;
    alu_flags_we = 1'b1;
    cyc(1'b0, 7'h00);
    alu_flags_we = 1'b0;
    cyc(1'b1, 7'h04);
    wait_load(4);
    chk1(core_stall_q, 1'b0);
    chk16(pc_value_q, sv_pc);
    chk16(sp_q, sp_m);
    chk16({8'h00, flag_register_q}, 16'h00D5);
  endtask
  task automatic give_verdict();
    $display("Errors %0d, checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog: the run needs well under 1000 cycles
  initial begin
    #20000;
    num_errors++;
    give_verdict();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rf_rd_a, rf_rd_b, rf_wr_addr, rf_wr_data, rf_wr_en8, rf_wr_en16, ds_addr, ds_we, ds_wdata} = '0;
    {ptr_sel, ptr_disp, ptr_inc, ptr_dec, io_addr, io_we, io_wdata, instr_done, pc_in} = '0;
    {op_push, op_pop, op_call, op_ret, op_handler_return_op, op_cli, op_sei, sleeping, alu_flags_we, alu_flags} = '0;
    {irq_enable, irq_event, irq_level, flag_w1c, reset_vector_relocate_fuse} = '0;
    step(2);
    nrst = 1'b1;
    step(3);
    chk16(sp_q, csi_pkg::TOP_OF_RAM);
    chk16(reset_vector_q, csi_pkg::APP_START);
    io(csi_pkg::IO_SPH, 8'h00, 1'b0);
    chk16({8'h00, io_rdata_q}, {8'h00, csi_pkg::TOP_OF_RAM[15:8]});
    io(csi_pkg::IO_SPL, 8'h34, 1'b1);
    io(csi_pkg::IO_SPH, 8'h02, 1'b1);
    io(6'h10, 8'h00, 1'b0);
    chk16(sp_q, sp_m);
    chk16({8'h00, io_rdata_q}, 16'h0000);
    foreach (st_ops[i]) begin
      cyc(1'b1, st_ops[i]);
      cyc(1'b0, 7'h00);
      step(6);
      chk16(sp_q, sp_m + st_dsp[i] + (i % 2 == 1 ? st_dsp[i - 1] : 16'h0000));
    end
    // First 16 passes fill every pair so the model never holds unknowns
    for (int i = 0; i < 48; i++) begin
      {ptr_inc, ptr_dec} = 2'b00;
      rf_wr_addr = (i < 16) ? 5'(2 * i) : 5'($random(seed));
      rf_wr_data = 16'($random(seed));
      rf_wr_en16 = (i < 16) || rf_wr_data[15];
      rf_wr_en8 = !rf_wr_en16;
      if (rf_wr_en16) {regs[rf_wr_addr | 5'h01], regs[rf_wr_addr & 5'h1E]} = rf_wr_data;
      else regs[rf_wr_addr] = rf_wr_data[7:0];
      step();
      {rf_wr_en8, rf_wr_en16} = 2'b00;
      {rf_rd_a, rf_rd_b, ptr_sel, ptr_disp} = 18'($random(seed));
      ds_addr = 16'($random(seed)) & 16'h003F;
      ptr_inc = (i >= 16) && rf_wr_data[0];
      ptr_dec = (i >= 16) && rf_wr_data[1];
      step();
      if (i >= 16) begin
        chk16({8'h00, rf_opa_q}, {8'h00, regs[rf_rd_a]});
        chk16({8'h00, rf_opb_q}, {8'h00, regs[rf_rd_b]});
        chk16(rf_opw_q, pair(rf_rd_a));
        chk16({8'h00, ds_rdata_q}, (ds_addr < 16'h0020) ? {8'h00, regs[ds_addr[4:0]]} : 16'h0000);
        chk16(ptr_addr_q, pair(pbase(ptr_sel)) + {10'h000, ptr_disp});
      end
      // Both strobes high leaves the pointer alone
      if (ptr_inc ^ ptr_dec) begin
        {regs[pbase(ptr_sel) + 5'h01], regs[pbase(ptr_sel)]} = pair(pbase(ptr_sel)) + (ptr_inc ? 16'h0001 : 16'hFFFF);
      end
    end
    {ptr_inc, ptr_dec} = 2'b00;
    irq_enable = 8'h6C;
    irq_event = 8'h28;
    step();
    irq_event = 8'h00;
    flag_w1c = 8'h20;
    chk16({8'h00, irq_flag_q}, 16'h0028);
    step();
    flag_w1c = 8'h00;
    chk16({8'h00, irq_flag_q}, 16'h0008);
    unmask();
    take(3, csi_pkg::APP_START, 4, 1'b0);
    irq_event = 8'h44;
    step();
    irq_event = 8'h00;
    back();
    cyc(1'b1, 7'h00);
    chk1(irq_ack_q, 1'b0);
    cyc(1'b1, 7'h02);
    chk1(irq_ack_q, 1'b0);
    unmask();
    take(2, csi_pkg::APP_START, 4, 1'b0);
    back();
    io(csi_pkg::IO_CORECTL, 8'h02, 1'b1);
    io(csi_pkg::IO_CORECTL, 8'h00, 1'b0);
    cyc(1'b1, 7'h00);
    chk1(irq_ack_q, 1'b0);
    take(6, csi_pkg::BOOT_START, 8, 1'b1);
    back();
    // Level request that vanishes before it is enabled must never fire
    irq_level = 8'h80;
    cyc(1'b1, 7'h00);
    irq_level = 8'h00;
    irq_enable = 8'hEC;
    cyc(1'b1, 7'h00);
    chk1(irq_ack_q, 1'b0);
    irq_level = 8'h80;
    take(7, csi_pkg::BOOT_START, 4, 1'b0);
    irq_level = 8'h00;
    back();
    reset_vector_relocate_fuse = 1'b1;
    step(2);
    chk16(reset_vector_q, csi_pkg::BOOT_START);
    give_verdict();
  end
endmodule // csi_core_ctrl_bench
